// ### virtual_partition_map_upper.sv
// Upper virtual partition map register: ids 4 to 7, access checks, lookup
// Assumes one system register access per cycle from the core pipeline
//
// Operation
// - Four 16-bit physical ids; id 7 top field, id 4 bottom field.
// - Highest map register index never exceeds 7.
// - Index 0 means this register does not exist.
// - Kernel and user ids translate only under their own map enables.
// - Entry n used only while its valid bit is 1.
// - Present only with feature, hypervisor control, index above 0.
// - No translation effect unless the hypervisor level is enabled.
// - The register is 64 bits wide.
// - Warm reset leaves fields undefined; here sys_rst loads RESET_VALUE 0, nothing relies on it.
// - Selected by op0 3, op1 4, CRn 10, CRm 6, op2 1.
// - User level access is always undefined.
// - Kernel read with both nested bits goes to deferred memory 0x948.
// - Kernel read with nested bit and no monitor trap traps class 0x18.
// - Monitor trap bit sends hypervisor access, and kernel access with nested bit only, to monitor.
// - Monitor trap is undefined when halted with secure debug off.
`timescale 1ns/1ps
module virtual_partition_map_upper #(
  parameter int ID_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration
  input wire logic partitioning_feature,
  input wire logic hypervisor_control_present,
  input wire logic [2:0] highest_map_register_index,
  input wire logic kernel_level_map_enable,
  input wire logic user_level_map_enable,
  input wire logic [3:0] map_entry_valid,
  // Access port
  input wire vpm_pkg::access_req_t req,
  input wire vpm_pkg::core_state_t cs,
  output vpm_pkg::access_rsp_t rsp,
  // Translation of kernel and user ids
  input wire logic [ID_W-1:0] kernel_vid,
  input wire logic [ID_W-1:0] user_vid,
  output logic [ID_W-1:0] kernel_pid,
  output logic [ID_W-1:0] user_pid,
  output logic kernel_hit,
  output logic user_hit
);
  import vpm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [63:0] map_r;
    access_rsp_t rsp_r;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic present;
  logic sel;
  logic [2:0] max_index;
  result_t chk_result;
  logic [5:0] chk_ec;

  // ==========================================================
  // Existence
  always_comb begin
    max_index = (highest_map_register_index > MAX_INDEX_LIMIT) ?
      MAX_INDEX_LIMIT : highest_map_register_index;
    present = partitioning_feature && hypervisor_control_present &&
      (max_index != 3'h0);
    sel = req.valid && enc_hit(req.enc);
  end

  vpm_access_check u_check (
    .level(req.level),
    .present(present),
    .cs(cs),
    .result(chk_result),
    .exc_class(chk_ec)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_r = '0;
    if (sel) begin
      st_nxt.rsp_r.valid = 1'b1;
      st_nxt.rsp_r.result = chk_result;
      st_nxt.rsp_r.exc_class = chk_ec;
      if (chk_result == RES_DEFER) begin
        st_nxt.rsp_r.mem_offset = DEFER_OFFSET;
      end
      if (chk_result == RES_DATA) begin
        if (req.write) begin
          st_nxt.map_r = req.wdata;
        end else begin
          st_nxt.rsp_r.rdata = st_r.map_r;
        end
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.rsp_r <= '0;
      st_r.map_r <= RESET_VALUE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rsp = st_r.rsp_r;

  // ==========================================================
  // Translation
  vpm_translate #(.ID_W(ID_W)) u_kernel (
    .map_value(st_r.map_r),
    .entry_valid(map_entry_valid),
    .enable(present && cs.hyp_enabled &&
      kernel_level_map_enable),
    .vid(kernel_vid),
    .hit(kernel_hit),
    .pid(kernel_pid)
  );

  vpm_translate #(.ID_W(ID_W)) u_user (
    .map_value(st_r.map_r),
    .entry_valid(map_entry_valid),
    .enable(present && cs.hyp_enabled &&
      user_level_map_enable),
    .vid(user_vid),
    .hit(user_hit),
    .pid(user_pid)
  );

endmodule

// ### virtual_partition_map_upper_tb.sv
// Testbench for the upper partition map register
// Assumes the checker is bound to the design
`timescale 1ns/1ps
module virtual_partition_map_upper_tb;
  import vpm_pkg::*;
  localparam logic [63:0] W = 64'h0a07_0a06_0a05_0a04;
  logic clk = 0, sys_rst = 1, feat = 1, hcp = 1, ken = 1, uen = 1, cke = 1;
  logic [2:0] idx = 3'h7;
  logic [3:0] mev = 4'hf;
  access_req_t req = '0;
  core_state_t cs = '0;
  access_rsp_t rsp;
  logic [15:0] kvid = 16'h0, uvid = 16'h0, kpid, upid;
  logic khit, uhit;
  int miscompares = 0, checks_done = 0;
  logic [4:0] absent [3] = '{5'h0f, 5'h17, 5'h18};
  logic [11:0] rows [11] = '{
    {2'h0, 7'h40, RES_UNDEF},
    {2'h1, 7'h70, RES_DEFER},
    {2'h1, 7'h60, RES_TRAP_HYP},
    {2'h1, 7'h6c, RES_TRAP_MON},
    {2'h1, 7'h6f, RES_UNDEF},
    {2'h1, 7'h00, RES_UNDEF},
    {2'h1, 7'h40, RES_UNDEF},
    {2'h2, 7'h4c, RES_TRAP_MON},
    {2'h2, 7'h4f, RES_UNDEF},
    {2'h2, 7'h40, RES_DATA},
    {2'h3, 7'h4c, RES_DATA}};
  initial forever #10 clk = ~clk;
  virtual_partition_map_upper i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(cke),
    .partitioning_feature(feat), .hypervisor_control_present(hcp),
    .highest_map_register_index(idx), .kernel_level_map_enable(ken),
    .user_level_map_enable(uen), .map_entry_valid(mev), .req(req),
    .cs(cs), .rsp(rsp), .kernel_vid(kvid), .user_vid(uvid),
    .kernel_pid(kpid), .user_pid(upid), .kernel_hit(khit),
    .user_hit(uhit));
  // ==========================================================
  // Compare and access tasks
  task automatic cmp_w(input logic [63:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic cmp_r(input result_t g, e);
    cmp_w(64'(g), 64'(e), "result");
  endtask
  task automatic acc(input logic [1:0] l, input logic w,
    input logic [63:0] d, input logic [6:0] c, input result_t er,
    input logic [63:0] ed);
    req = '{1'b1, w, '{ENC_OP0, ENC_OP1, ENC_CRN, ENC_CRM, ENC_OP2}, l, d};
    cs = core_state_t'(c);
    @(negedge clk);
    req.valid = 1'b0;
    cmp_w(64'(rsp.valid), 64'h1, "valid");
    cmp_r(rsp.result, er);
    if (!w) cmp_w(rsp.rdata, ed, "rdata");
    if (er == RES_DEFER)
      cmp_w(64'(rsp.mem_offset), 64'h948, "off");
    if (er inside {RES_TRAP_HYP, RES_TRAP_MON})
      cmp_w(64'(rsp.exc_class), 64'h18, "class");
    @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    acc(2'h2, 1'b1, W, 7'h40, RES_DATA, 64'h0);
    acc(2'h3, 1'b0, 64'h0, 7'h40, RES_DATA, W);
    for (int i = 0; i < 11; i++) begin
      acc(rows[i][11:10], 1'b0, 64'h0, rows[i][9:3],
        result_t'(rows[i][2:0]), rows[i][2:0] == RES_DATA ? W : 64'h0);
    end
    $display("test table done");
    acc(2'h1, 1'b1, 64'h0, 7'h60, RES_TRAP_HYP, 64'h0);
    acc(2'h3, 1'b0, 64'h0, 7'h40, RES_DATA, W);
    req = '{1'b1, 1'b0, '{ENC_OP0, ENC_OP1, ENC_CRN, ENC_CRM, 3'h0},
      2'h3, 64'h0};
    @(negedge clk);
    req.valid = 1'b0;
    cmp_w(64'(rsp.valid), 64'h0, "foreign");
    $display("test refusal done");
    kvid = 16'h5;
    uvid = 16'h7;
    mev = 4'h2;
    #1 cmp_w(64'({khit, kpid}), 64'h10a05, "kpid");
    cmp_w(64'(uhit), 64'h0, "uhit");
    mev = 4'ha;
    #1 cmp_w(64'({uhit, upid}), 64'h10a07, "upid");
    uen = 0;
    #1 cmp_w(64'(uhit), 64'h0, "uen");
    cmp_w(64'(upid), 64'h7, "upid pass");
    cs.hyp_enabled = 0;
    #1 cmp_w(64'(khit), 64'h0, "hyp");
    @(negedge clk);
    $display("test lookup done");
    for (int j = 0; j < 3; j++) begin
      {feat, hcp, idx} = absent[j];
      acc(2'h3, 1'b0, 64'h0, 7'h40, RES_UNDEF, 64'h0);
    end
    $display("test absent done");
    {feat, hcp, idx} = 5'h1f;
    cke = 1'b0;
    req.valid = 1'b1;
    @(negedge clk);
    req.valid = 1'b0;
    cmp_w(64'(rsp.valid), 64'h0, "frozen");
    cke = 1'b1;
    @(negedge clk);
    cmp_w(64'(rsp.valid), 64'h0, "thawed");
    $display("test freeze done");
    sys_rst = 1'b1;
    req.valid = 1'b1;
    repeat (2) @(negedge clk);
    cmp_w(64'(rsp.valid), 64'h0, "in reset");
    req.valid = 1'b0;
    sys_rst = 1'b0;
    @(negedge clk);
    cmp_w(64'(rsp.valid), 64'h0, "released");
    acc(2'h3, 1'b1, ~W, 7'h40, RES_DATA, 64'h0);
    acc(2'h3, 1'b0, 64'h0, 7'h40, RES_DATA, ~W);
    $display("test reset done");
    results();
  end
endmodule

// ### vpm_access_check.sv
// Access checks for the upper partition map register
// Assumes core state is stable while a request is valid
`timescale 1ns/1ps
module vpm_access_check (
  // Request
  input wire logic [1:0] level,
  input wire logic present,
  input wire vpm_pkg::core_state_t cs,
  // Outcome
  output vpm_pkg::result_t result,
  output logic [5:0] exc_class
);
  import vpm_pkg::*;

  logic mon_trap;

  always_comb begin
    mon_trap = cs.monitor_present && cs.lower_access_trap;
    result = RES_DATA;
    exc_class = 6'h0;
    if (!present) begin
      result = RES_UNDEF;
    end else begin
      case (level)
        2'h0: result = RES_UNDEF;
        2'h1: begin
          if (cs.hyp_enabled && cs.nested_deferral_bit &&
              cs.nested_virtualisation_bit) begin
            result = RES_DEFER;
          end else if (cs.hyp_enabled && cs.nested_virtualisation_bit) begin
            if (mon_trap) begin
              if (cs.halted && cs.secure_debug_disabled) begin
                result = RES_UNDEF;
              end else begin
                result = RES_TRAP_MON;
                exc_class = EC_SYSREG;
              end
            end else begin
              result = RES_TRAP_HYP;
              exc_class = EC_SYSREG;
            end
          end else begin
            result = RES_UNDEF;
          end
        end
        2'h2: begin
          if (mon_trap) begin
            if (cs.halted && cs.secure_debug_disabled) begin
              result = RES_UNDEF;
            end else begin
              result = RES_TRAP_MON;
              exc_class = EC_SYSREG;
            end
          end else begin
            result = RES_DATA;
          end
        end
        2'h3: result = RES_DATA;
        default: result = RES_UNDEF;
      endcase
    end
  end
endmodule

// ### vpm_asserts.sv
// Checker for the upper partition map register ports
// Assumes it is bound onto the top module
`timescale 1ns/1ps
module vpm_asserts #(
  parameter int ID_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration
  input wire logic partitioning_feature,
  input wire logic hypervisor_control_present,
  input wire logic [2:0] highest_map_register_index,
  input wire logic kernel_level_map_enable,
  input wire logic [3:0] map_entry_valid,
  // Access and lookup
  input wire vpm_pkg::access_req_t req,
  input wire vpm_pkg::core_state_t cs,
  input wire vpm_pkg::access_rsp_t rsp,
  input wire logic [ID_W-1:0] kernel_vid,
  input wire logic kernel_hit
);
  import vpm_pkg::*;
  wire logic take = req.valid && clk_en && enc_hit(req.enc);
  wire logic here = partitioning_feature && hypervisor_control_present &&
    highest_map_register_index != 3'h0;
  wire logic lv1 = take && here && req.level == 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Properties
  a_answer_next: assert property (take |=> rsp.valid)
    else $error("no answer");
  a_no_stray: assert property (rsp.valid |->
    $past(take) || ($past(rsp.valid) && !$past(clk_en)))
    else $error("stray answer");
  a_user_undef: assert property (take && req.level == 2'h0
    |=> rsp.result == RES_UNDEF) else $error("user access");
  a_absent_undef: assert property (take && !here
    |=> rsp.result == RES_UNDEF) else $error("absent access");
  a_defer_offset: assert property (lv1 && cs.hyp_enabled &&
    cs.nested_virtualisation_bit && cs.nested_deferral_bit
    |=> rsp.result == RES_DEFER && rsp.mem_offset == DEFER_OFFSET)
    else $error("defer");
  a_trap_class: assert property (rsp.valid &&
    rsp.result inside {RES_TRAP_HYP, RES_TRAP_MON}
    |-> rsp.exc_class == EC_SYSREG) else $error("class");
  a_refused_zero: assert property (rsp.valid &&
    rsp.result != RES_DATA |-> rsp.rdata == 64'h0) else $error("rdata");
  a_mon_data: assert property (take && here &&
    req.level == 2'h3 |=> rsp.result == RES_DATA) else $error("monitor");
  a_hit_valid: assert property (kernel_hit |->
    kernel_level_map_enable && cs.hyp_enabled &&
    kernel_vid[ID_W-1:2] == 'h1 && map_entry_valid[kernel_vid[1:0]])
    else $error("hit");
endmodule
bind virtual_partition_map_upper vpm_asserts #(.ID_W(ID_W)) i_chk (
  .clk, .sys_rst, .clk_en, .partitioning_feature,
  .hypervisor_control_present, .highest_map_register_index,
  .kernel_level_map_enable, .map_entry_valid, .req, .cs, .rsp,
  .kernel_vid, .kernel_hit);

// ### vpm_pkg.sv
// Package: shared constants and carriers for the partition map register
// Assumes a core-side system register access port and core state inputs
package vpm_pkg;

  // ==========================================================
  // Sizes
  localparam int REG_W = 64;
  localparam int ENTRY_W = 16;
  localparam int ENTRY_N = 4;
  localparam int FIRST_VID = 4;
  localparam logic [2:0] MAX_INDEX_LIMIT = 3'h7;

  // ==========================================================
  // Field positions
  localparam int PHYS4_LSB = 0;
  localparam int PHYS5_LSB = 16;
  localparam int PHYS6_LSB = 32;
  localparam int PHYS7_LSB = 48;

  // ==========================================================
  // Encoding of the register
  localparam logic [1:0] ENC_OP0 = 2'h3;
  localparam logic [2:0] ENC_OP1 = 3'h4;
  localparam logic [3:0] ENC_CRN = 4'ha;
  localparam logic [3:0] ENC_CRM = 4'h6;
  localparam logic [2:0] ENC_OP2 = 3'h1;

  // ==========================================================
  // Access outcomes
  localparam logic [5:0] EC_SYSREG = 6'h18;
  localparam logic [11:0] DEFER_OFFSET = 12'h948;
  localparam logic [63:0] RESET_VALUE = 64'h0;

  typedef enum logic [2:0] {
    RES_NONE = 3'b000,
    RES_DATA = 3'b001,
    RES_UNDEF = 3'b010,
    RES_TRAP_HYP = 3'b011,
    RES_TRAP_MON = 3'b100,
    RES_DEFER = 3'b101
  } result_t;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_enc_t;

  typedef struct packed {
    logic valid;
    logic write;
    sysreg_enc_t enc;
    logic [1:0] level;
    logic [63:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic hyp_enabled;
    logic nested_virtualisation_bit;
    logic nested_deferral_bit;
    logic monitor_present;
    logic lower_access_trap;
    logic halted;
    logic secure_debug_disabled;
  } core_state_t;

  typedef struct packed {
    logic valid;
    result_t result;
    logic [63:0] rdata;
    logic [5:0] exc_class;
    logic [11:0] mem_offset;
  } access_rsp_t;

  function automatic logic enc_hit(input sysreg_enc_t e);
    return e.op0 == ENC_OP0 && e.op1 == ENC_OP1 && e.crn == ENC_CRN &&
           e.crm == ENC_CRM && e.op2 == ENC_OP2;
  endfunction

endpackage

// ### vpm_translate.sv
// Virtual to physical partition id lookup for ids 4 to 7
// Assumes map and valid bits come from registered state
`timescale 1ns/1ps
module vpm_translate #(
  parameter int ID_W = 16
) (
  // Lookup
  input wire logic [63:0] map_value,
  input wire logic [3:0] entry_valid,
  input wire logic enable,
  input wire logic [ID_W-1:0] vid,
  // Result
  output logic hit,
  output logic [ID_W-1:0] pid
);
  import vpm_pkg::*;

  logic [1:0] idx;
  logic in_range;

  always_comb begin
    idx = vid[1:0];
    in_range = (vid >> 2) == ID_W'(1);
    hit = enable && in_range && entry_valid[idx];
    pid = hit ? map_value[idx*ENTRY_W +: ENTRY_W] : vid;
  end
endmodule
